// *** hw/olt_pkg.sv ***
// Shared constants of the loop-back test engine: register map, reset values,
// frame formats and field positions.
// Assumes an 8-bit register port and a byte-wide transmit stream.
package olt_pkg;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam logic [7:0] OLT_ADDR_FRAME_COUNT = 8'h44;
    localparam logic [7:0] OLT_ADDR_PATTERN_SEL = 8'h45;
    localparam logic [7:0] OLT_ADDR_CRC_ERR_CNT = 8'h46;
    localparam logic [7:0] OLT_ADDR_TIMEOUT_CNT = 8'h47;
    localparam logic [7:0] OLT_ADDR_GOOD_CNT = 8'h48;
    localparam logic [7:0] OLT_ADDR_ADD_STATUS = 8'h49;

    // ----------------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------------
    localparam logic [7:0] OLT_FRAME_COUNT_RST = 8'h07;
    localparam logic [7:0] OLT_PATTERN_SEL_RST = 8'h00;
    localparam logic [7:0] OLT_FRAME_COUNT_MAX = 8'h64;
    localparam logic [7:0] OLT_TALLY_MAX = 8'hFF;
    localparam logic [1:0] OLT_MODEL_RST = 2'h0;

    // ----------------------------------------------------------------------
    // Additional status field positions
    // ----------------------------------------------------------------------
    localparam int OLT_ST_HW_VER_HI = 7;
    localparam int OLT_ST_HW_VER_LO = 6;
    localparam int OLT_ST_MODEL_HI = 5;
    localparam int OLT_ST_MODEL_LO = 4;
    localparam int OLT_ST_REMOTE_STOP = 3;
    localparam int OLT_ST_DWELL_EXP = 2;
    localparam int OLT_ST_REPLY_EXP = 1;
    localparam int OLT_ST_LINK_LOST = 0;

    // ----------------------------------------------------------------------
    // Frame formats
    // ----------------------------------------------------------------------
    localparam logic [10:0] OLT_LEN_SHORT = 11'h040;
    localparam logic [10:0] OLT_LEN_LONG = 11'h5EE;
    localparam logic [10:0] OLT_FCS_BYTES = 11'h004;
    localparam logic [15:0] OLT_DATA_55AA = 16'h55AA;
    localparam logic [15:0] OLT_DATA_0F0F = 16'h0F0F;
    localparam logic [15:0] OLT_DATA_FF00 = 16'hFF00;
    localparam logic [15:0] OLT_ETHER_TYPE = 16'h0800;
    localparam logic [10:0] OLT_IDX_DA_LAST = 11'h005;
    localparam logic [10:0] OLT_IDX_SA_FIRST = 11'h006;
    localparam logic [10:0] OLT_IDX_TYPE_HI = 11'h00C;
    localparam logic [10:0] OLT_IDX_TYPE_LO = 11'h00D;

    typedef enum logic [1:0] {
        OLT_GEN_IDLE,
        OLT_GEN_SEND
    } olt_gen_state_t;

endpackage

// *** hw/olt_top.sv ***
// Loop-back test engine with result tallies, byte FIFO and status register.
// Assumes returned-frame results and timer expiries arrive as one-cycle
// pulses from the frame parser and maintenance timers, all on clk_sys_i.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------------------
module olt_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // The pointer wrap bit only works for a power-of-two depth of at least 2.
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_params
        $error("olt_fifo needs a width of at least 1 and a power-of-two depth of at least 2.");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire do_push = in_valid_i && !full;
    wire do_pop = out_ready_i && !empty;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_sys_i)
    begin
        if (do_push)
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (do_pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule

// ------------------------------------------------------------------------
// Test engine
// ------------------------------------------------------------------------
module olt_top #(
    parameter logic [1:0] HW_VERSION = 2'h2, // Arbitrary value.
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Station address, first byte in bits 47:40
    input wire logic [47:0] station_addr_i,
    // Returned frame results and maintenance events
    input wire logic ret_good_i,
    input wire logic ret_crc_err_i,
    input wire logic ret_timeout_i,
    input wire logic remote_loop_stop_i,
    input wire logic loop_dwell_expired_i,
    input wire logic reply_timer_expired_i,
    input wire logic fiber_link_lost_i,
    // Maintenance counter clear towards the valid transmit and receive counters
    output logic mc_cnt_clear_o,
    // Test frame byte stream
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    // Burst in progress
    output logic burst_busy_o
);
    import olt_pkg::*;

    // --------------------------------------------------------------------
    // Pattern decode and saturating tally update
    // --------------------------------------------------------------------
    function automatic logic [27:0] olt_decode(input logic [7:0] sel);
        // Returns {long, broadcast, 16-bit data, 10 spare zero bits}.
        logic [27:0] r;
        r = {1'b0, 1'b0, OLT_DATA_55AA, 10'h000};
        unique case (sel)
            8'h01: r = {1'b1, 1'b0, OLT_DATA_55AA, 10'h000};
            8'h02: r = {1'b0, 1'b1, OLT_DATA_55AA, 10'h000};
            8'h04: r = {1'b1, 1'b1, OLT_DATA_55AA, 10'h000};
            8'h08: r = {1'b0, 1'b0, OLT_DATA_0F0F, 10'h000};
            8'h10: r = {1'b1, 1'b0, OLT_DATA_0F0F, 10'h000};
            8'h20: r = {1'b0, 1'b1, OLT_DATA_0F0F, 10'h000};
            8'h40: r = {1'b1, 1'b1, OLT_DATA_0F0F, 10'h000};
            8'h80: r = {1'b1, 1'b1, OLT_DATA_FF00, 10'h000};
            default: r = {1'b0, 1'b0, OLT_DATA_55AA, 10'h000};
        endcase
        return r;
    endfunction

    function automatic logic [7:0] olt_tally(input logic [7:0] cnt, input logic ev,
                                             input logic clr);
        logic [7:0] n;
        n = cnt;
        if (clr)
            n = ev ? 8'h01 : 8'h00;
        else if (ev && cnt != OLT_TALLY_MAX)
            n = cnt + 8'h01;
        return n;
    endfunction

    // --------------------------------------------------------------------
    // Register decode
    // --------------------------------------------------------------------
    wire wr_count = reg_wr_i && reg_addr_i == OLT_ADDR_FRAME_COUNT;
    wire wr_pattern = reg_wr_i && reg_addr_i == OLT_ADDR_PATTERN_SEL;
    wire wr_status = reg_wr_i && reg_addr_i == OLT_ADDR_ADD_STATUS;
    wire rd_status = reg_rd_i && reg_addr_i == OLT_ADDR_ADD_STATUS;
    wire clr_tally = wr_count && reg_wdata_i == 8'h00;
    wire start_burst = wr_count && reg_wdata_i != 8'h00;

    logic [7:0] frame_count_r;
    logic [7:0] pattern_sel_r;
    logic [7:0] crc_tally_r;
    logic [7:0] timeout_tally_r;
    logic [7:0] good_tally_r;
    logic [1:0] model_r;
    logic [2:0] sticky_r;
    logic [7:0] rdata_r;
    logic clr_pulse_r;

    wire [2:0] sticky_set = {remote_loop_stop_i, loop_dwell_expired_i, reply_timer_expired_i};
    wire [2:0] sticky_nxt = sticky_set | (rd_status ? 3'h0 : sticky_r);
    wire [7:0] status_val = {HW_VERSION, model_r, sticky_r, fiber_link_lost_i};

    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr_i)
            OLT_ADDR_FRAME_COUNT: rd_mux = frame_count_r;
            OLT_ADDR_PATTERN_SEL: rd_mux = pattern_sel_r;
            OLT_ADDR_CRC_ERR_CNT: rd_mux = crc_tally_r;
            OLT_ADDR_TIMEOUT_CNT: rd_mux = timeout_tally_r;
            OLT_ADDR_GOOD_CNT: rd_mux = good_tally_r;
            OLT_ADDR_ADD_STATUS: rd_mux = status_val;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            frame_count_r <= OLT_FRAME_COUNT_RST;
            pattern_sel_r <= OLT_PATTERN_SEL_RST;
            crc_tally_r <= 8'h00;
            timeout_tally_r <= 8'h00;
            good_tally_r <= 8'h00;
            model_r <= OLT_MODEL_RST;
            sticky_r <= 3'h0;
            rdata_r <= 8'h00;
            clr_pulse_r <= 1'b0;
        end
        else
        begin
            if (wr_count)
                frame_count_r <= reg_wdata_i;
            if (wr_pattern)
                pattern_sel_r <= reg_wdata_i;
            if (wr_status)
                model_r <= reg_wdata_i[OLT_ST_MODEL_HI:OLT_ST_MODEL_LO];
            crc_tally_r <= olt_tally(crc_tally_r, ret_crc_err_i, clr_tally);
            timeout_tally_r <= olt_tally(timeout_tally_r, ret_timeout_i, clr_tally);
            good_tally_r <= olt_tally(good_tally_r, ret_good_i, clr_tally);
            sticky_r <= sticky_nxt;
            rdata_r <= reg_rd_i ? rd_mux : 8'h00;
            clr_pulse_r <= clr_tally;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign mc_cnt_clear_o = clr_pulse_r;

    // --------------------------------------------------------------------
    // Frame generator
    // --------------------------------------------------------------------
    olt_gen_state_t state_r;
    logic [7:0] remain_r;
    logic [10:0] idx_r;
    logic [7:0] da_last_r;
    logic [27:0] fmt_r;
    logic [7:0] sent_r;
    logic [7:0] want_r;
    logic fifo_in_ready;

    wire fmt_long = fmt_r[27];
    wire fmt_bcast = fmt_r[26];
    wire [15:0] fmt_data = fmt_r[25:10];
    wire [10:0] last_idx = (fmt_long ? OLT_LEN_LONG : OLT_LEN_SHORT) - OLT_FCS_BYTES - 11'h001;
    wire sending = state_r == OLT_GEN_SEND;
    wire push = sending && fifo_in_ready;
    wire frame_end = push && idx_r == last_idx;
    wire [47:0] dest_addr = fmt_bcast ? 48'hFFFF_FFFF_FFFF : {station_addr_i[47:8], da_last_r};

    logic [7:0] gen_byte;
    always_comb
    begin
        if (idx_r < OLT_IDX_SA_FIRST)
            gen_byte = dest_addr[8'(6'd47 - 6'(idx_r[2:0]) * 6'd8) -: 8];
        else if (idx_r < OLT_IDX_TYPE_HI)
            gen_byte = station_addr_i[8'(6'd47 - 6'(idx_r[2:0] - 3'd6) * 6'd8) -: 8];
        else if (idx_r == OLT_IDX_TYPE_HI)
            gen_byte = OLT_ETHER_TYPE[15:8];
        else if (idx_r == OLT_IDX_TYPE_LO)
            gen_byte = OLT_ETHER_TYPE[7:0];
        else
            gen_byte = idx_r[0] ? fmt_data[7:0] : fmt_data[15:8];
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= OLT_GEN_IDLE;
            remain_r <= 8'h00;
            idx_r <= 11'h000;
            da_last_r <= 8'h00;
            fmt_r <= 28'h0000000;
            sent_r <= 8'h00;
            want_r <= 8'h00;
        end
        else
        begin
            unique case (state_r)
                OLT_GEN_IDLE:
                begin
                    if (start_burst)
                    begin
                        state_r <= OLT_GEN_SEND;
                        remain_r <= reg_wdata_i;
                        want_r <= reg_wdata_i;
                        sent_r <= 8'h00;
                        fmt_r <= olt_decode(pattern_sel_r);
                        da_last_r <= station_addr_i[7:0] + 8'h01;
                        idx_r <= 11'h000;
                    end
                end
                OLT_GEN_SEND:
                begin
                    if (frame_end)
                    begin
                        idx_r <= 11'h000;
                        remain_r <= remain_r - 8'h01;
                        sent_r <= sent_r + 8'h01;
                        da_last_r <= da_last_r + 8'h01;
                        if (remain_r == 8'h01)
                            state_r <= OLT_GEN_IDLE;
                    end
                    else if (push)
                        idx_r <= idx_r + 11'h001;
                end
                default: state_r <= OLT_GEN_IDLE;
            endcase
        end
    end

    assign burst_busy_o = sending;

    olt_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .in_data_i({frame_end, gen_byte}),
        .in_valid_i(sending),
        .in_ready_o(fifo_in_ready),
        .out_data_o({tx_last_o, tx_data_o}),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i)
    );

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    sequence s_zero_write;
        clr_tally && !ret_crc_err_i && !ret_timeout_i && !ret_good_i;
    endsequence

    property p_zero_clear;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_zero_write |=> crc_tally_r == 8'h00 && timeout_tally_r == 8'h00 &&
            good_tally_r == 8'h00 && mc_cnt_clear_o;
    endproperty
    a_zero_clear: assert property (p_zero_clear) else $error("Zero count write did not clear.");

    property p_burst_len;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(sending) |-> sent_r == want_r;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("Burst frame count wrong.");

    property p_frame_len;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        frame_end |-> idx_r == (fmt_long ? 11'd1513 : 11'd59);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("Frame length wrong.");

    property p_da_step;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        frame_end && remain_r > 8'h01 |=> da_last_r == $past(da_last_r) + 8'h01 && sending;
    endproperty
    a_da_step: assert property (p_da_step) else $error("Destination byte did not step.");

    property p_da_last;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        push && !fmt_bcast && idx_r == OLT_IDX_DA_LAST |-> gen_byte == da_last_r;
    endproperty
    a_da_last: assert property (p_da_last) else $error("Destination last byte wrong.");

    property p_type_field;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        push && idx_r == OLT_IDX_TYPE_HI |-> gen_byte == 8'h08 ##1 (!push || gen_byte == 8'h00);
    endproperty
    a_type_field: assert property (p_type_field) else $error("Type field wrong.");

    property p_crc_sat;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        crc_tally_r == 8'hFF && !clr_tally |=> crc_tally_r == 8'hFF;
    endproperty
    a_crc_sat: assert property (p_crc_sat) else $error("CRC tally wrapped.");

    property p_good_inc;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ret_good_i && !clr_tally && good_tally_r != 8'hFF |=>
            good_tally_r == $past(good_tally_r) + 8'h01;
    endproperty
    a_good_inc: assert property (p_good_inc) else $error("Good tally did not count.");

    property p_timeout_inc;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ret_timeout_i && !clr_tally && timeout_tally_r != 8'hFF |=>
            timeout_tally_r == $past(timeout_tally_r) + 8'h01;
    endproperty
    a_timeout_inc: assert property (p_timeout_inc) else $error("Timeout tally wrong.");

    property p_read_clear;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_status && !remote_loop_stop_i |=> !sticky_r[2] && reg_rdata_o[7:6] == HW_VERSION;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("Stop flag not cleared.");

    property p_link_bit;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_status |=> reg_rdata_o[0] == $past(fiber_link_lost_i);
    endproperty
    a_link_bit: assert property (p_link_bit) else $error("Link bit wrong.");
endmodule

// *** testbench/olt_far_end.sv ***
// Far-end model: takes the test frame stream and answers every frame.
// Assumes one result pulse per frame, of the kind the bench selects.
`timescale 1ns/1ps

module olt_far_end (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Frame stream
    input wire logic tx_last_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // Results: kind 0 good, 1 CRC error, 2 timeout
    input wire logic [1:0] res_kind_i,
    output logic ret_good_o,
    output logic ret_crc_err_o,
    output logic ret_timeout_o
);
    logic done_r;

    // Random stalls make the stream hold each byte until taken.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_ready_o <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            tx_ready_o <= ($urandom % 4) != 0;
            done_r <= tx_valid_i && tx_ready_o && tx_last_i;
        end
    end

    assign ret_good_o = done_r && res_kind_i == 2'h0;
    assign ret_crc_err_o = done_r && res_kind_i == 2'h1;
    assign ret_timeout_o = done_r && res_kind_i == 2'h2;
endmodule

// *** testbench/oam_loopback_test_counters_tb.sv ***
// Self-checking bench of the loop-back test engine.
// Assumes the far-end model answers each frame with one result pulse.
`timescale 1ns/1ps

module oam_loopback_test_counters_tb;
    import olt_pkg::*;

    localparam logic [1:0] HW_VER = 2'h3; // Arbitrary value.
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [47:0] station_addr_i = 48'h0;
    logic ret_good_i, ret_crc_err_i, ret_timeout_i;
    logic [2:0] evt_r = 3'h0;
    logic fiber_link_lost_i = 1'b0;
    logic mc_cnt_clear_o, tx_last_o, tx_valid_o, tx_ready_i, burst_busy_o;
    logic [7:0] tx_data_o;
    logic [1:0] res_kind = 2'h0;
    logic [7:0] codes[9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    logic [8:0] exp_q[$];
    int tally[3] = '{0, 0, 0};
    int failures = 0;
    int check_count = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    olt_top #(.HW_VERSION(HW_VER), .FIFO_DEPTH(32)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .station_addr_i(station_addr_i),
        .ret_good_i(ret_good_i), .ret_crc_err_i(ret_crc_err_i),
        .ret_timeout_i(ret_timeout_i), .remote_loop_stop_i(evt_r[2]),
        .loop_dwell_expired_i(evt_r[1]), .reply_timer_expired_i(evt_r[0]),
        .fiber_link_lost_i(fiber_link_lost_i), .mc_cnt_clear_o(mc_cnt_clear_o),
        .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .burst_busy_o(burst_busy_o));

    olt_far_end far (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .tx_last_i(tx_last_o),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .res_kind_i(res_kind),
        .ret_good_o(ret_good_i), .ret_crc_err_o(ret_crc_err_i),
        .ret_timeout_o(ret_timeout_i));

    // ----------------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({8'h00, reg_rdata_o}, {8'h00, e});
    endtask

    // Builds the expected bytes, with the last-byte flag on top.
    task automatic push_frames(input logic [7:0] pat, input int n);
        logic [15:0] dat;
        logic bc;
        int len;
        len = |(pat & 8'hD5) ? 1514 : 60;
        bc = |(pat & 8'hE6);
        dat = pat[7] ? 16'hFF00 : (|pat[6:3] ? 16'h0F0F : 16'h55AA);
        for (int k = 0; k < n; k++)
        begin
            for (int i = 0; i < 5; i++)
                exp_q.push_back({1'b0, bc ? 8'hFF : station_addr_i[47-8*i -: 8]});
            exp_q.push_back({1'b0, bc ? 8'hFF : station_addr_i[7:0] + 8'h01 + 8'(k)});
            for (int i = 0; i < 6; i++)
                exp_q.push_back({1'b0, station_addr_i[47-8*i -: 8]});
            exp_q.push_back(9'h008);
            exp_q.push_back(9'h000);
            for (int i = 0; i < len - 14; i++)
                exp_q.push_back({i == len - 15, i[0] ? dat[7:0] : dat[15:8]});
        end
    endtask

    task automatic burst(input logic [7:0] pat, input logic [7:0] n, input logic [1:0] kind);
        int t;
        res_kind <= kind;
        wr(OLT_ADDR_PATTERN_SEL, pat);
        push_frames(pat, n);
        wr(OLT_ADDR_FRAME_COUNT, n);
        #1;
        chk({15'h0, burst_busy_o}, 16'h0001);
        wr(OLT_ADDR_PATTERN_SEL, 8'h80);
        tally[kind] = (tally[kind] + n > 255) ? 255 : tally[kind] + n;
        t = 0;
        while ((burst_busy_o !== 1'b0 || exp_q.size() != 0) && t < 40000)
        begin
            @(posedge clk_sys_i);
            t++;
        end
        if (t == 40000)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
            report_and_stop();
        end
        repeat (3) @(posedge clk_sys_i);
    endtask

    // Every accepted byte is compared; a byte beyond the count never matches.
    always @(posedge clk_sys_i)
        if (rst_n_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
            chk({7'h00, tx_last_o, tx_data_o},
                exp_q.size() ? {7'h00, exp_q.pop_front()} : 16'hFFFF);

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h45F3));
        station_addr_i <= {40'($urandom) << 8, 8'hFE};
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        chk_rd(OLT_ADDR_FRAME_COUNT, 8'h07);
        chk_rd(OLT_ADDR_PATTERN_SEL, 8'h00);
        for (int a = 8'h46; a < 8'h49; a++)
            chk_rd(8'(a), 8'h00);
        chk_rd(OLT_ADDR_ADD_STATUS, {HW_VER, 6'h00});
        chk_rd(8'h50, 8'h00);
        $display("test reset_values done");
        foreach (codes[i])
            burst(codes[i], codes[i] == 8'h00 ? 8'h03 : 8'h01, 2'h0);
        chk_rd(OLT_ADDR_GOOD_CNT, 8'(tally[0]));
        $display("test patterns done");
        burst(8'h02, 8'h02, 2'h1);
        burst(8'h20, 8'h04, 2'h2);
        wr(OLT_ADDR_CRC_ERR_CNT, 8'h55);
        chk_rd(OLT_ADDR_CRC_ERR_CNT, 8'(tally[1]));
        chk_rd(OLT_ADDR_TIMEOUT_CNT, 8'(tally[2]));
        $display("test error_tallies done");
        repeat (3) burst(8'h00, 8'h64, 2'h0);
        chk_rd(OLT_ADDR_GOOD_CNT, 8'(tally[0]));
        $display("test saturation done");
        wr(OLT_ADDR_FRAME_COUNT, 8'h00);
        #1;
        chk({15'h0, mc_cnt_clear_o}, 16'h0001);
        @(posedge clk_sys_i);
        #1;
        chk({15'h0, mc_cnt_clear_o}, 16'h0000);
        for (int a = 8'h46; a < 8'h49; a++)
            chk_rd(8'(a), 8'h00);
        $display("test clear done");
        wr(OLT_ADDR_ADD_STATUS, 8'hFF);
        fiber_link_lost_i <= 1'b1;
        for (int b = 0; b < 3; b++)
        begin
            @(posedge clk_sys_i);
            evt_r <= 3'(1 << b);
            @(posedge clk_sys_i);
            evt_r <= 3'h0;
            chk_rd(OLT_ADDR_ADD_STATUS, {HW_VER, 2'h3, 3'(1 << b), 1'b1});
            chk_rd(OLT_ADDR_ADD_STATUS, {HW_VER, 2'h3, 3'h0, 1'b1});
        end
        @(posedge clk_sys_i);
        fiber_link_lost_i <= 1'b0;
        chk_rd(OLT_ADDR_ADD_STATUS, {HW_VER, 6'h30});
        $display("test status done");
        report_and_stop();
    end
endmodule
